// ---- shared/preamp_pkg.sv ----
// constants and types for the microphone pre-amplifier gain and bias registers
package preamp_pkg;

   // ****************************************
   // bus geometry
   // ****************************************
   localparam int          ADDR_W        = 9;
   localparam int          DATA_W        = 32;
   localparam int          REG_W         = 16;
   localparam int          BE_W          = 4;

   // ****************************************
   // register indices, byte address is four times the index
   // ****************************************
   localparam logic [6:0]  IDX_POWER_MANAGEMENT_ONE = 7'h08;
   localparam logic [6:0]  IDX_MIC_BIAS_CONTROL     = 7'h4a;
   localparam logic [6:0]  IDX_LEFT_PREAMP_VOLUME   = 7'h50;
   localparam logic [6:0]  IDX_RIGHT_PREAMP_VOLUME  = 7'h51;
   localparam logic [ADDR_W-1:0] ADDR_POWER_MANAGEMENT_ONE = {IDX_POWER_MANAGEMENT_ONE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MIC_BIAS_CONTROL     = {IDX_MIC_BIAS_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_LEFT_PREAMP_VOLUME   = {IDX_LEFT_PREAMP_VOLUME, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_RIGHT_PREAMP_VOLUME  = {IDX_RIGHT_PREAMP_VOLUME, 2'b00};

   // ****************************************
   // field positions
   // ****************************************
   localparam int          POS_BIAS_IN_PM1  = 4;
   localparam int          POS_BIAS_IN_CTL  = 15;
   localparam int          POS_BIAS_LEVEL   = 14;
   localparam int          POS_SILENCE      = 14;
   localparam int          POS_ZERO_CROSS   = 13;
   localparam int          POS_COMMIT       = 8;
   localparam int          POS_GAIN_MSB     = 7;
   localparam int          POS_GAIN_LSB     = 2;
   localparam int          GAIN_W           = 6;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [GAIN_W-1:0] GAIN_RST       = 6'h10;
   localparam logic              SILENCE_RST    = 1'b0;
   localparam logic              ZERO_CROSS_RST = 1'b0;
   localparam logic              BIAS_ON_RST    = 1'b0;
   localparam logic              BIAS_LEVEL_RST = 1'b0;
   localparam logic [DATA_W-1:0] READ_ZERO      = 32'h0000_0000;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [0:0] {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_t;

   // drive of one pre-amplifier: same gain to both terminals
   typedef struct packed {
      logic [GAIN_W-1:0] gain_noninv;
      logic [GAIN_W-1:0] gain_inv;
      logic              silence;
      logic              mixer_link;
   } chan_ctrl_t;

   // field write into one channel register
   typedef struct packed {
      logic              gain_wr;
      logic [GAIN_W-1:0] gain;
      logic              flags_wr;
      logic              zero_cross;
      logic              silence;
   } chan_write_t;

endpackage

// ---- src/preamp_gain_channel.sv ----
// one pre-amplifier channel: shadow gain, commit, zero-cross release and mute
`timescale 1ns/10ps
module preamp_gain_channel (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   input  wire preamp_pkg::chan_write_t      wr_i,
   input  wire logic                         commit_i,
   input  wire logic                         crossing_i,
   output logic [preamp_pkg::GAIN_W-1:0]     shadow_gain_o,
   output logic                              zero_cross_en_o,
   output logic                              silence_o,
   output preamp_pkg::chan_ctrl_t            ctrl_o
);
   import preamp_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [GAIN_W-1:0] shadow_r,  shadow_nxt;
   logic [GAIN_W-1:0] applied_r, applied_nxt;
   logic [GAIN_W-1:0] target_r,  target_nxt;
   logic              pending_r, pending_nxt;
   logic              zc_r,      zc_nxt;
   logic              silence_r, silence_nxt;

   always_comb begin
      shadow_nxt  = shadow_r;
      applied_nxt = applied_r;
      target_nxt  = target_r;
      pending_nxt = pending_r;
      zc_nxt      = zc_r;
      silence_nxt = silence_r;
      if (wr_i.gain_wr) begin
         shadow_nxt = wr_i.gain;                                 // R12
      end
      if (wr_i.flags_wr) begin
         zc_nxt      = wr_i.zero_cross;
         silence_nxt = wr_i.silence;                             // R6
      end
      if (pending_r && crossing_i) begin
         applied_nxt = target_r;                                 // R5
         pending_nxt = 1'b0;
      end
      // a new commit overrides any release still waiting
      if (commit_i) begin                                        // R2
         if (zc_nxt) begin
            target_nxt  = shadow_nxt;                            // R5
            pending_nxt = 1'b1;
         end else begin
            applied_nxt = shadow_nxt;                            // R4
            pending_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shadow_r  <= GAIN_RST;                                  // R8
         applied_r <= GAIN_RST;
         target_r  <= GAIN_RST;
         pending_r <= 1'b0;
         zc_r      <= ZERO_CROSS_RST;
         silence_r <= SILENCE_RST;
      end else if (ce_i) begin
         shadow_r  <= shadow_nxt;
         applied_r <= applied_nxt;
         target_r  <= target_nxt;
         pending_r <= pending_nxt;
         zc_r      <= zc_nxt;
         silence_r <= silence_nxt;
      end
   end

   assign shadow_gain_o      = shadow_r;
   assign zero_cross_en_o    = zc_r;
   assign silence_o          = silence_r;
   assign ctrl_o.gain_noninv = applied_r;                        // R1
   assign ctrl_o.gain_inv    = applied_r;                        // R1
   assign ctrl_o.silence     = silence_r;                        // R6
   assign ctrl_o.mixer_link  = ~silence_r;                       // R6

endmodule // preamp_gain_channel

// ---- src/mic_preamp_gain_bias_regs.sv ----
// register bank for the two microphone pre-amplifiers and the microphone bias
//
// Notes on behaviour
// R1: each channel's one gain drives both of its input pins, inverting and non-inverting alike.
// R2: a written gain waits until a 1 is written to the shared commit bit at position 8 of either channel register.
// R3: a commit from either channel register releases both channels' pending gains together.
// R4: with zero-cross update off (bit 13 clear) a committed gain is applied at once.
// R5: with zero-cross update on, a committed gain is applied at the first zero crossing of that channel's signal.
// R6: silence bit 14 set mutes the pre-amplifier and cuts it from the record mixer; clear means normal operation.
// R7: the gain field is bits 7 to 2, 000000 is -12 dB rising 0.75 dB a step to 35.25 dB at 111111.
// R8: the right gain field matches the left, and both reset to 010000, which is 0 dB.
// R9: bias enable low leaves the bias output off and high impedance, high turns it on, and it resets low.
// R10: the bias enable is one bit seen at bit 4 of power management one and bit 15 of bias control.
// R11: bias level select bit 14 picks 0.9 of the analog supply when low and 0.75 when high, resetting low.
// R12: readback of a gain returns the last written value whether or not it has been applied.
`timescale 1ns/10ps
module mic_preamp_gain_bias_regs (
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   input  wire logic                              ce_i,
   // avalon-mm slave
   input  wire logic [preamp_pkg::ADDR_W-1:0]     avs_address,
   input  wire logic                              avs_read,
   input  wire logic                              avs_write,
   input  wire logic [preamp_pkg::DATA_W-1:0]     avs_writedata,
   input  wire logic [preamp_pkg::BE_W-1:0]       avs_byteenable,
   output logic [preamp_pkg::DATA_W-1:0]          avs_readdata,
   output logic                                   avs_waitrequest,
   // zero-crossing comparators of the analog signal, asynchronous
   input  wire logic                              left_signal_sign_i,
   input  wire logic                              right_signal_sign_i,
   // analog controls
   output preamp_pkg::chan_ctrl_t                 left_preamp_ctrl_o,
   output preamp_pkg::chan_ctrl_t                 right_preamp_ctrl_o,
   output logic                                   bias_output_on_o,
   output logic                                   bias_output_pin_oe_o,
   output logic                                   bias_level_select_o
);
   import preamp_pkg::*;

   // ****************************************
   // bus decode
   // ****************************************
   logic                    req;
   logic                    aligned;
   logic                    hit_pm1;
   logic                    hit_bias;
   logic                    hit_left;
   logic                    hit_right;
   logic                    lane_lo;
   logic                    lane_hi;

   assign req       = avs_read | avs_write;
   assign aligned   = (avs_address[1:0] == 2'b00);
   assign hit_pm1   = aligned && (avs_address == ADDR_POWER_MANAGEMENT_ONE);
   assign hit_bias  = aligned && (avs_address == ADDR_MIC_BIAS_CONTROL);
   assign hit_left  = aligned && (avs_address == ADDR_LEFT_PREAMP_VOLUME);
   assign hit_right = aligned && (avs_address == ADDR_RIGHT_PREAMP_VOLUME);
   assign lane_lo   = avs_byteenable[0];
   assign lane_hi   = avs_byteenable[1];

   // ****************************************
   // bus handshake
   // ****************************************
   bus_state_t              state_r, state_nxt;
   logic [DATA_W-1:0]       readdata_r, readdata_nxt;
   logic                    wr_strobe;
   logic [REG_W-1:0]        read_word;

   // read data is captured in the idle cycle and stands while waitrequest is low
   always_comb begin
      state_nxt    = state_r;
      readdata_nxt = readdata_r;
      unique case (state_r)
         BUS_IDLE: begin
            if (req) begin
               state_nxt    = BUS_ANSWER;
               readdata_nxt = avs_read ? {16'h0000, read_word} : READ_ZERO;
            end
         end
         BUS_ANSWER: begin
            state_nxt = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r    <= BUS_IDLE;
         readdata_r <= READ_ZERO;
      end else if (ce_i) begin
         state_r    <= state_nxt;
         readdata_r <= readdata_nxt;
      end
   end

   assign avs_waitrequest = req && (state_r != BUS_ANSWER || !ce_i);
   assign avs_readdata    = readdata_r;
   // a write takes effect on the edge where waitrequest is low
   assign wr_strobe       = avs_write && state_r == BUS_ANSWER;

   // ****************************************
   // bias controls
   // ****************************************
   logic                    bias_on_r,    bias_on_nxt;
   logic                    bias_level_r, bias_level_nxt;

   always_comb begin
      bias_on_nxt    = bias_on_r;
      bias_level_nxt = bias_level_r;
      if (wr_strobe && hit_pm1 && lane_lo) begin
         bias_on_nxt = avs_writedata[POS_BIAS_IN_PM1];                        // R10
      end
      if (wr_strobe && hit_bias && lane_hi) begin
         bias_on_nxt    = avs_writedata[POS_BIAS_IN_CTL];                     // R10
         bias_level_nxt = avs_writedata[POS_BIAS_LEVEL];                      // R11
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bias_on_r    <= BIAS_ON_RST;                                         // R9
         bias_level_r <= BIAS_LEVEL_RST;                                      // R11
      end else if (ce_i) begin
         bias_on_r    <= bias_on_nxt;
         bias_level_r <= bias_level_nxt;
      end
   end

   assign bias_output_on_o     = bias_on_r;                                   // R9
   assign bias_output_pin_oe_o = bias_on_r;                                   // R9
   assign bias_level_select_o  = bias_level_r;                                // R11

   // ****************************************
   // zero-crossing detection
   // ****************************************
   logic [1:0]              sign_meta_r;
   logic [1:0]              sign_sync_r;
   logic [1:0]              sign_prev_r;
   logic [1:0]              crossing;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sign_meta_r <= 2'b00;
         sign_sync_r <= 2'b00;
         sign_prev_r <= 2'b00;
      end else if (ce_i) begin
         sign_meta_r <= {right_signal_sign_i, left_signal_sign_i};
         sign_sync_r <= sign_meta_r;
         sign_prev_r <= sign_sync_r;
      end
   end

   // a change of sign in either direction marks a zero crossing
   assign crossing = sign_sync_r ^ sign_prev_r;

   // ****************************************
   // channel writes and shared commit
   // ****************************************
   chan_write_t             left_wr;
   chan_write_t             right_wr;
   logic                    commit;

   always_comb begin
      left_wr.gain_wr     = wr_strobe && hit_left && lane_lo;
      left_wr.gain        = avs_writedata[POS_GAIN_MSB:POS_GAIN_LSB];         // R7
      left_wr.flags_wr    = wr_strobe && hit_left && lane_hi;
      left_wr.zero_cross  = avs_writedata[POS_ZERO_CROSS];
      left_wr.silence     = avs_writedata[POS_SILENCE];
      right_wr.gain_wr    = wr_strobe && hit_right && lane_lo;
      right_wr.gain       = avs_writedata[POS_GAIN_MSB:POS_GAIN_LSB];         // R8
      right_wr.flags_wr   = wr_strobe && hit_right && lane_hi;
      right_wr.zero_cross = avs_writedata[POS_ZERO_CROSS];
      right_wr.silence    = avs_writedata[POS_SILENCE];
   end

   // one commit pulse feeds both channels
   assign commit = wr_strobe && lane_hi && (hit_left || hit_right)
                   && avs_writedata[POS_COMMIT];                              // R2 R3

   // ****************************************
   // channels
   // ****************************************
   logic [GAIN_W-1:0]       left_shadow;
   logic [GAIN_W-1:0]       right_shadow;
   logic                    left_zc;
   logic                    right_zc;
   logic                    left_silence;
   logic                    right_silence;

   preamp_gain_channel u_left (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .ce_i            (ce_i),
      .wr_i            (left_wr),
      .commit_i        (commit),                                              // R3
      .crossing_i      (crossing[0]),
      .shadow_gain_o   (left_shadow),
      .zero_cross_en_o (left_zc),
      .silence_o       (left_silence),
      .ctrl_o          (left_preamp_ctrl_o)
   );

   preamp_gain_channel u_right (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .ce_i            (ce_i),
      .wr_i            (right_wr),
      .commit_i        (commit),                                              // R3
      .crossing_i      (crossing[1]),
      .shadow_gain_o   (right_shadow),
      .zero_cross_en_o (right_zc),
      .silence_o       (right_silence),
      .ctrl_o          (right_preamp_ctrl_o)
   );

   // ****************************************
   // readback
   // ****************************************
   // commit bit is write-only and reads as zero
   always_comb begin
      read_word = 16'h0000;
      if (hit_pm1) begin
         read_word[POS_BIAS_IN_PM1] = bias_on_r;                              // R10
      end else if (hit_bias) begin
         read_word[POS_BIAS_IN_CTL] = bias_on_r;                              // R10
         read_word[POS_BIAS_LEVEL]  = bias_level_r;
      end else if (hit_left) begin
         read_word[POS_SILENCE]                 = left_silence;
         read_word[POS_ZERO_CROSS]              = left_zc;
         read_word[POS_GAIN_MSB:POS_GAIN_LSB]   = left_shadow;                // R12
      end else if (hit_right) begin
         read_word[POS_SILENCE]                 = right_silence;
         read_word[POS_ZERO_CROSS]              = right_zc;
         read_word[POS_GAIN_MSB:POS_GAIN_LSB]   = right_shadow;               // R12
      end
   end

endmodule // mic_preamp_gain_bias_regs

// ---- testbench/mic_preamp_gain_bias_regs_properties.sv ----
// port checker of the pre-amplifier gain and bias register bank
`timescale 1ns/10ps
module mic_preamp_gain_bias_regs_properties
   import preamp_pkg::*;
(
   input wire logic                          clk_i,
   input wire logic                          rst_i,
   input wire logic                          ce_i,
   input wire logic [preamp_pkg::ADDR_W-1:0] avs_address,
   input wire logic                          avs_read,
   input wire logic                          avs_write,
   input wire logic [preamp_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [preamp_pkg::BE_W-1:0]   avs_byteenable,
   input wire logic [preamp_pkg::DATA_W-1:0] avs_readdata,
   input wire logic                          avs_waitrequest,
   input wire logic                          left_signal_sign_i,
   input wire logic                          right_signal_sign_i,
   input wire preamp_pkg::chan_ctrl_t        left_preamp_ctrl_o,
   input wire preamp_pkg::chan_ctrl_t        right_preamp_ctrl_o,
   input wire logic                          bias_output_on_o,
   input wire logic                          bias_output_pin_oe_o,
   input wire logic                          bias_level_select_o
);
   // ****************************************
   // accepted transfers and properties
   // ****************************************
   logic wr_ok;
   logic rd_ok;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign rd_ok = avs_read && !avs_waitrequest;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   gain_terms_a: assert property (left_preamp_ctrl_o.gain_inv == left_preamp_ctrl_o.gain_noninv &&
      right_preamp_ctrl_o.gain_inv == right_preamp_ctrl_o.gain_noninv) else $error("gain terminals differ");
   bias_oe_a: assert property (bias_output_pin_oe_o == bias_output_on_o) else $error("bias drive mismatch");
   reset_vals_a: assert property ($fell(rst_i) && $past(ce_i) |->
      left_preamp_ctrl_o.gain_inv == GAIN_RST && right_preamp_ctrl_o.gain_inv == GAIN_RST &&
      !bias_output_on_o && !bias_level_select_o) else $error("reset values wrong");
   left_apply_a: assert property (wr_ok && avs_address == ADDR_LEFT_PREAMP_VOLUME && &avs_byteenable[1:0] &&
      avs_writedata[POS_COMMIT] && !avs_writedata[POS_ZERO_CROSS] |=>
      left_preamp_ctrl_o.gain_inv == $past(avs_writedata[POS_GAIN_MSB:POS_GAIN_LSB])) else $error("gain not applied");
   left_silence_a: assert property (wr_ok && avs_address == ADDR_LEFT_PREAMP_VOLUME && avs_byteenable[1] |=>
      left_preamp_ctrl_o.silence == $past(avs_writedata[POS_SILENCE]) &&
      left_preamp_ctrl_o.mixer_link != $past(avs_writedata[POS_SILENCE])) else $error("silence wrong");
   pm1_bias_a: assert property (wr_ok && avs_address == ADDR_POWER_MANAGEMENT_ONE && avs_byteenable[0] |=>
      bias_output_on_o == $past(avs_writedata[POS_BIAS_IN_PM1])) else $error("bias via pm1 wrong");
   ctl_bias_a: assert property (wr_ok && avs_address == ADDR_MIC_BIAS_CONTROL && avs_byteenable[1] |=>
      bias_output_on_o == $past(avs_writedata[POS_BIAS_IN_CTL]) &&
      bias_level_select_o == $past(avs_writedata[POS_BIAS_LEVEL])) else $error("bias via ctl wrong");
   rd_pm1_a: assert property (rd_ok && avs_address == ADDR_POWER_MANAGEMENT_ONE |->
      avs_readdata[POS_BIAS_IN_PM1] == bias_output_on_o) else $error("pm1 readback wrong");
   rd_ctl_a: assert property (rd_ok && avs_address == ADDR_MIC_BIAS_CONTROL |->
      avs_readdata[15:14] == {bias_output_on_o, bias_level_select_o}) else $error("ctl readback wrong");
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce_i |=> !avs_waitrequest || !ce_i)
      else $error("answer late");

   commit_c: cover property (wr_ok && avs_writedata[POS_COMMIT]);
   release_c: cover property ($changed(left_preamp_ctrl_o.gain_inv));
   readback_c: cover property (rd_ok && avs_address == ADDR_MIC_BIAS_CONTROL);
endmodule // mic_preamp_gain_bias_regs_properties

bind mic_preamp_gain_bias_regs mic_preamp_gain_bias_regs_properties i_mic_preamp_gain_bias_regs_properties (
   .clk_i, .rst_i, .ce_i, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .left_signal_sign_i, .right_signal_sign_i, .left_preamp_ctrl_o, .right_preamp_ctrl_o,
   .bias_output_on_o, .bias_output_pin_oe_o, .bias_level_select_o);

// ---- testbench/tb_mic_preamp_gain_bias_regs.sv ----
// self-checking bench of the pre-amplifier gain and bias register bank
`timescale 1ns/10ps
module tb_mic_preamp_gain_bias_regs;
   import preamp_pkg::*;
   logic                     clk_i;
   logic                     rst_i;
   logic                     ce_i;
   logic [ADDR_W-1:0]        avs_address;
   logic                     avs_read;
   logic                     avs_write;
   logic [DATA_W-1:0]        avs_writedata;
   logic [BE_W-1:0]          avs_byteenable;
   logic [DATA_W-1:0]        avs_readdata;
   logic                     avs_waitrequest;
   logic                     left_signal_sign_i;
   logic                     right_signal_sign_i;
   chan_ctrl_t               left_preamp_ctrl_o;
   chan_ctrl_t               right_preamp_ctrl_o;
   logic                     bias_output_on_o;
   logic                     bias_output_pin_oe_o;
   logic                     bias_level_select_o;
   int                       fail_count;
   int                       num_checks;

   mic_preamp_gain_bias_regs i_mic_preamp_gain_bias_regs (.clk_i, .rst_i, .ce_i, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .left_signal_sign_i, .right_signal_sign_i,
      .left_preamp_ctrl_o, .right_preamp_ctrl_o, .bias_output_on_o, .bias_output_pin_oe_o, .bias_level_select_o);

   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // waitrequest and readdata are taken at the rising edge, before that edge's updates land
   // a slave that never answers is ended by the watchdog
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      logic w;
      @(posedge clk_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk_i);
         w = avs_waitrequest;
         q = avs_readdata;
      end while (w !== 1'h0);
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask

   task automatic wr(input logic [8:0] a, input logic [15:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'h1, a, {16'h0, d}, be, q);
   endtask

   task automatic rd_chk(input logic [8:0] a, input logic [15:0] e);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, 4'hf, q);
      check($sformatf("readback %h", a), {16'h0, e}, q);
   endtask

   task automatic chk_st(input logic [5:0] gl, gr, input logic sl, sr, on, lv);
      @(negedge clk_i);
      check("left ctrl", {18'h0, gl, gl, sl, ~sl}, {18'h0, left_preamp_ctrl_o});
      check("right ctrl", {18'h0, gr, gr, sr, ~sr}, {18'h0, right_preamp_ctrl_o});
      check("bias", {29'h0, on, on, lv}, {29'h0, bias_output_on_o, bias_output_pin_oe_o, bias_level_select_o});
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      chk_st(6'h10, 6'h10, 1'h0, 1'h0, 1'h0, 1'h0);
      rd_chk(ADDR_LEFT_PREAMP_VOLUME, 16'h0040);
      rd_chk(ADDR_RIGHT_PREAMP_VOLUME, 16'h0040);
      rd_chk(ADDR_MIC_BIAS_CONTROL, 16'h0000);
      rd_chk(ADDR_POWER_MANAGEMENT_ONE, 16'h0000);
      $display("reset test done");
   endtask

   task automatic t_commit();
      wr(ADDR_LEFT_PREAMP_VOLUME, 16'h00fc, 4'h3);
      chk_st(6'h10, 6'h10, 1'h0, 1'h0, 1'h0, 1'h0);
      rd_chk(ADDR_LEFT_PREAMP_VOLUME, 16'h00fc);
      wr(ADDR_RIGHT_PREAMP_VOLUME, 16'h0104, 4'h3);
      chk_st(6'h3f, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0);
      rd_chk(ADDR_RIGHT_PREAMP_VOLUME, 16'h0004);
      $display("commit test done");
   endtask

   task automatic t_zero_cross();
      wr(ADDR_LEFT_PREAMP_VOLUME, 16'h2100, 4'h3);
      repeat (6) @(posedge clk_i);
      chk_st(6'h3f, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0);
      @(posedge clk_i);
      left_signal_sign_i <= ~left_signal_sign_i;
      repeat (4) @(posedge clk_i);
      chk_st(6'h00, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0);
      rd_chk(ADDR_LEFT_PREAMP_VOLUME, 16'h2000);
      wr(ADDR_LEFT_PREAMP_VOLUME, 16'h0120, 4'h3);
      chk_st(6'h08, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0);
      $display("zero cross test done");
   endtask

   task automatic t_mute();
      wr(ADDR_LEFT_PREAMP_VOLUME, 16'h4000, 4'h2);
      chk_st(6'h08, 6'h01, 1'h1, 1'h0, 1'h0, 1'h0);
      wr(ADDR_LEFT_PREAMP_VOLUME, 16'h0000, 4'h2);
      chk_st(6'h08, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0);
      $display("mute test done");
   endtask

   task automatic t_bias();
      wr(ADDR_POWER_MANAGEMENT_ONE, 16'h0010, 4'h1);
      chk_st(6'h08, 6'h01, 1'h0, 1'h0, 1'h1, 1'h0);
      rd_chk(ADDR_MIC_BIAS_CONTROL, 16'h8000);
      wr(ADDR_MIC_BIAS_CONTROL, 16'h4000, 4'h2);
      chk_st(6'h08, 6'h01, 1'h0, 1'h0, 1'h0, 1'h1);
      rd_chk(ADDR_POWER_MANAGEMENT_ONE, 16'h0000);
      wr(9'h004, 16'hffff, 4'hf);
      rd_chk(9'h004, 16'h0000);
      chk_st(6'h08, 6'h01, 1'h0, 1'h0, 1'h0, 1'h1);
      $display("bias test done");
   endtask

   initial begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      fail_count = 0;
      num_checks = 0;
      rst_i = 1'h1;
      ce_i = 1'h1;
      avs_address = 9'h000;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      left_signal_sign_i = 1'h0;
      right_signal_sign_i = 1'h0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      t_reset();
      t_commit();
      t_zero_cross();
      t_mute();
      t_bias();
      tally_and_finish();
   end
endmodule // tb_mic_preamp_gain_bias_regs
